// ==== pci_cmd_pkg.sv ====
// shared constants for the pci command control bank
// assumes a 16-bit configuration access port and a single pci clock
package pci_cmd_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] CMD_REG_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_REG_OFFSET = 8'h06;
	localparam logic [15:0] CMD_RESET = 16'h0000;

	// ****************************************************************
	// command field positions
	// ****************************************************************
	localparam int IO_SPACE_BIT = 0;
	localparam int MEM_SPACE_BIT = 1;
	localparam int BUS_MASTER_BIT = 2;
	localparam int SPECIAL_CYCLE_BIT = 3;
	localparam int WRITE_INVAL_BIT = 4;
	localparam int PALETTE_SNOOP_BIT = 5;
	localparam int PARITY_RESP_BIT = 6;
	localparam int STEPPING_BIT = 7;
	localparam int SERR_ENABLE_BIT = 8;
	localparam int DET_PARITY_BIT = 15;

	// ****************************************************************
	// capability choices
	// ****************************************************************
	localparam logic [1:0] STEP_NEVER = 2'h0;
	localparam logic [1:0] STEP_ALWAYS = 2'h1;
	localparam logic [1:0] STEP_OPTIONAL = 2'h2;
	localparam logic [1:0] STEP_MODE = STEP_NEVER;
	localparam logic STEP_RESET = 1'h1;
	localparam logic PALETTE_SNOOP_IMPL = 1'h0;
	localparam logic SPECIAL_CYCLE_IMPL = 1'h0;

	// ****************************************************************
	// target address space of an incoming request
	// ****************************************************************
	typedef enum logic [3:0] {
		SPACE_CFG = 4'h1,
		SPACE_MEM = 4'h2,
		SPACE_IO = 4'h4,
		SPACE_SPECIAL = 4'h8
	} space_t;

endpackage

// ==== pci_parity_gen.sv ====
// even parity generator over address/data and byte enables
// assumes ad and cbe come from logic on the same pci clock
`timescale 1ns/1ps
module pci_parity_gen (
	input wire logic mclk, // pci clock
	input wire logic rst_n, // async reset, active low
	input wire logic [31:0] ad, // address/data driven this cycle
	input wire logic [3:0] cbe, // command/byte enables driven this cycle
	output logic par_q // parity for the following cycle
);

	// ****************************************************************
	// parity register
	// ****************************************************************
	// parity always generated
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			par_q <= 1'h0;
		end else begin
			par_q <= ^{ad, cbe};
		end
	end

	parity_even_a: assert property (@(posedge mclk) disable iff (!rst_n)
		par_q == ^{$past(ad), $past(cbe)})
		else $error("parity output does not match previous bus value");

endmodule

// ==== pci_command_control_bits.sv ====
// command register bank gating pci target, master and error logic
// assumes config, target, master and parity-check strobes come from same-clock logic
`timescale 1ns/1ps
// Functional notes
// - system error driver is enabled only while its enable bit is one
// - stepping bit reads zero, one, or writable resetting to one, per capability
// - with parity response set, detected data parity errors drive the perr pin
// - with parity response clear, errors set status bit 15 only
// - parity response bit resets to zero
// - bus parity is always generated regardless of checking
// - palette snoop on: palette writes are not claimed, and are snooped only with i/o space enabled
// - palette snoop off: palette writes handled like any access
// - write and invalidate only issued when its enable bit is one
// - special cycles ignored unless the monitor bit is one
// - no master access unless bus master bit is one
// - memory accesses claimed only with memory space enabled
// - i/o accesses claimed only with i/o space enabled
// - all-zero command leaves only configuration accesses answered
module pci_command_control_bits
	import pci_cmd_pkg::*;
(
	input wire logic mclk, // pci clock
	input wire logic rst_n, // async reset, active low
	input wire logic cfg_wr, // config write strobe
	input wire logic cfg_rd, // config read strobe
	input wire logic [7:0] cfg_addr, // config byte address of halfword
	input wire logic [1:0] cfg_be, // byte enables of halfword
	input wire logic [15:0] cfg_wdata, // config write data
	output logic [15:0] cfg_rdata_q, // config read data
	output logic cfg_ack_q, // config access done
	input wire logic tgt_req, // target request decoded
	input wire logic [3:0] tgt_space, // space of request, space_t code
	input wire logic tgt_palette_wr, // request is a palette register write
	output logic tgt_claim_q, // claim the access
	output logic tgt_snoop_q, // snoop data without claiming
	input wire logic mst_req, // internal master wants the bus
	input wire logic mst_want_inval, // master wants write and invalidate
	output logic mst_go_q, // master may start
	output logic mst_inval_q, // use write and invalidate command
	output logic step_en_q, // address/data stepping on
	input wire logic data_perr_det, // data parity error detected pulse
	input wire logic addr_perr_det, // address parity error detected pulse
	output logic perr_n_q, // perr pin output level
	output logic perr_oe_q, // perr pin output enable
	output logic serr_n_q, // serr open-drain output level
	output logic serr_oe_q, // serr output enable
	output logic det_parity_err_q, // sticky detected parity error
	input wire logic [31:0] ad_out, // address/data driven by device
	input wire logic [3:0] cbe_out, // cbe driven by device
	output logic par_out_q // generated parity
);

	// ****************************************************************
	// command bits
	// ****************************************************************
	logic io_space_enable_q;
	logic memory_space_enable_q;
	logic bus_master_enable_q;
	logic special_cycle_monitor_q;
	logic write_invalidate_enable_q;
	logic palette_snoop_enable_q;
	logic parity_error_response_q;
	logic stepping_control_q;
	logic system_error_driver_enable_q;
	logic cmd_lo_wr;
	logic cmd_hi_wr;
	logic stat_hi_wr;
	logic [15:0] cmd_view;

	assign cmd_lo_wr = cfg_wr && (cfg_addr == CMD_REG_OFFSET) && cfg_be[0];
	assign cmd_hi_wr = cfg_wr && (cfg_addr == CMD_REG_OFFSET) && cfg_be[1];
	assign stat_hi_wr = cfg_wr && (cfg_addr == STATUS_REG_OFFSET) && cfg_be[1];

	// low byte enables, optional bits stay zero when absent; parity response resets to zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			io_space_enable_q <= CMD_RESET[IO_SPACE_BIT];
			memory_space_enable_q <= CMD_RESET[MEM_SPACE_BIT];
			bus_master_enable_q <= CMD_RESET[BUS_MASTER_BIT];
			write_invalidate_enable_q <= CMD_RESET[WRITE_INVAL_BIT];
			parity_error_response_q <= CMD_RESET[PARITY_RESP_BIT];
			special_cycle_monitor_q <= CMD_RESET[SPECIAL_CYCLE_BIT];
			palette_snoop_enable_q <= CMD_RESET[PALETTE_SNOOP_BIT];
		end else if (cmd_lo_wr) begin
			io_space_enable_q <= cfg_wdata[IO_SPACE_BIT];
			memory_space_enable_q <= cfg_wdata[MEM_SPACE_BIT];
			bus_master_enable_q <= cfg_wdata[BUS_MASTER_BIT];
			write_invalidate_enable_q <= cfg_wdata[WRITE_INVAL_BIT];
			parity_error_response_q <= cfg_wdata[PARITY_RESP_BIT];
			special_cycle_monitor_q <= cfg_wdata[SPECIAL_CYCLE_BIT] & SPECIAL_CYCLE_IMPL;
			palette_snoop_enable_q <= cfg_wdata[PALETTE_SNOOP_BIT] & PALETTE_SNOOP_IMPL;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stepping_control_q <= (STEP_MODE == STEP_NEVER) ? 1'h0 : STEP_RESET;
		end else if (STEP_MODE != STEP_OPTIONAL) begin
			stepping_control_q <= (STEP_MODE == STEP_ALWAYS);
		end else if (cmd_lo_wr) begin
			stepping_control_q <= cfg_wdata[STEPPING_BIT];
		end
	end

	// high byte system error enable
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			system_error_driver_enable_q <= CMD_RESET[SERR_ENABLE_BIT];
		end else if (cmd_hi_wr) begin
			system_error_driver_enable_q <= cfg_wdata[SERR_ENABLE_BIT];
		end
	end

	// register view; reserved bits read zero
	always_comb begin
		cmd_view = 16'h0000;
		cmd_view[IO_SPACE_BIT] = io_space_enable_q;
		cmd_view[MEM_SPACE_BIT] = memory_space_enable_q;
		cmd_view[BUS_MASTER_BIT] = bus_master_enable_q;
		cmd_view[SPECIAL_CYCLE_BIT] = special_cycle_monitor_q;
		cmd_view[WRITE_INVAL_BIT] = write_invalidate_enable_q;
		cmd_view[PALETTE_SNOOP_BIT] = palette_snoop_enable_q;
		cmd_view[PARITY_RESP_BIT] = parity_error_response_q;
		cmd_view[STEPPING_BIT] = stepping_control_q;
		cmd_view[SERR_ENABLE_BIT] = system_error_driver_enable_q;
	end

	// ****************************************************************
	// config read port
	// ****************************************************************
	// read data and one-cycle ack; unmapped reads zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_rdata_q <= 16'h0000;
			cfg_ack_q <= 1'h0;
		end else begin
			cfg_ack_q <= cfg_wr | cfg_rd;
			if (cfg_rd && cfg_addr == CMD_REG_OFFSET) begin
				cfg_rdata_q <= cmd_view;
			end else if (cfg_rd && cfg_addr == STATUS_REG_OFFSET) begin
				cfg_rdata_q <= {det_parity_err_q, 15'h0000};
			end else begin
				cfg_rdata_q <= 16'h0000;
			end
		end
	end

	// ****************************************************************
	// target decode
	// ****************************************************************
	// claim and snoop decisions one cycle after the request
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tgt_claim_q <= 1'h0;
			tgt_snoop_q <= 1'h0;
		end else begin
			tgt_claim_q <= 1'h0;
			tgt_snoop_q <= 1'h0;
			if (tgt_req) begin
				case (tgt_space)
					SPACE_CFG: begin
						tgt_claim_q <= 1'h1;
					end
					SPACE_MEM: begin
						tgt_claim_q <= memory_space_enable_q;
					end
					SPACE_IO: begin
						if (tgt_palette_wr && palette_snoop_enable_q) begin
							tgt_snoop_q <= io_space_enable_q;
						end else begin
							tgt_claim_q <= io_space_enable_q;
						end
					end
					SPACE_SPECIAL: begin
						tgt_snoop_q <= special_cycle_monitor_q;
					end
					default: begin
						tgt_claim_q <= 1'h0;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// master gating
	// ****************************************************************
	// master start and command choice
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mst_go_q <= 1'h0;
			mst_inval_q <= 1'h0;
		end else begin
			mst_go_q <= mst_req & bus_master_enable_q;
			mst_inval_q <= mst_req & bus_master_enable_q & mst_want_inval & write_invalidate_enable_q;
		end
	end

	// stepping control to the bus logic
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			step_en_q <= 1'h0;
		end else begin
			step_en_q <= stepping_control_q;
		end
	end

	// ****************************************************************
	// parity error handling
	// ****************************************************************
	// sticky flag, write one clears, set wins
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			det_parity_err_q <= 1'h0;
		end else if (data_perr_det || addr_perr_det) begin
			det_parity_err_q <= 1'h1;
		end else if (stat_hi_wr && cfg_wdata[DET_PARITY_BIT]) begin
			det_parity_err_q <= 1'h0;
		end
	end

	// perr driven one cycle when response on
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			perr_n_q <= 1'h1;
			perr_oe_q <= 1'h0;
		end else begin
			perr_n_q <= !(data_perr_det && parity_error_response_q);
			perr_oe_q <= data_perr_det && parity_error_response_q;
		end
	end

	// serr driver only with its enable
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			serr_n_q <= 1'h1;
			serr_oe_q <= 1'h0;
		end else begin
			serr_n_q <= !(addr_perr_det && parity_error_response_q && system_error_driver_enable_q);
			serr_oe_q <= addr_perr_det && parity_error_response_q && system_error_driver_enable_q;
		end
	end

	pci_parity_gen u_parity (
		.mclk(mclk),
		.rst_n(rst_n),
		.ad(ad_out),
		.cbe(cbe_out),
		.par_q(par_out_q)
	);

	// ****************************************************************
	// checks
	// ****************************************************************
	serr_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
		serr_oe_q |-> $past(system_error_driver_enable_q) && !serr_n_q)
		else $error("serr driven while its driver is disabled");
	step_fixed_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(STEP_MODE == STEP_NEVER) |-> !stepping_control_q)
		else $error("stepping bit set on a device that never steps");
	perr_drive_a: assert property (@(posedge mclk) disable iff (!rst_n)
		data_perr_det && parity_error_response_q |=> perr_oe_q && !perr_n_q)
		else $error("perr not driven on parity error");
	perr_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
		data_perr_det && !parity_error_response_q |=> !perr_oe_q && det_parity_err_q)
		else $error("parity error mishandled with response off");
	snoop_palette_a: assert property (@(posedge mclk) disable iff (!rst_n)
		tgt_req && tgt_space == SPACE_IO && tgt_palette_wr && palette_snoop_enable_q |=> !tgt_claim_q)
		else $error("palette write claimed while snooping");
	inval_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
		mst_inval_q |-> $past(write_invalidate_enable_q) && mst_go_q)
		else $error("write and invalidate used while disabled");
	special_ignore_a: assert property (@(posedge mclk) disable iff (!rst_n)
		tgt_req && tgt_space == SPACE_SPECIAL |=> !tgt_claim_q && (tgt_snoop_q == $past(special_cycle_monitor_q)))
		else $error("special cycle handling wrong");
	master_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
		mst_go_q |-> $past(bus_master_enable_q) && $past(mst_req))
		else $error("master started while bus master disabled");
	mem_claim_a: assert property (@(posedge mclk) disable iff (!rst_n)
		tgt_req && tgt_space == SPACE_MEM |=> tgt_claim_q == $past(memory_space_enable_q))
		else $error("memory claim does not follow enable");
	io_claim_a: assert property (@(posedge mclk) disable iff (!rst_n)
		tgt_req && tgt_space == SPACE_IO && !(tgt_palette_wr && palette_snoop_enable_q) |=>
		tgt_claim_q == $past(io_space_enable_q))
		else $error("i/o claim does not follow enable");
	zero_cmd_a: assert property (@(posedge mclk) disable iff (!rst_n)
		cmd_view == 16'h0000 && tgt_req && tgt_space != SPACE_CFG |=> !tgt_claim_q && !tgt_snoop_q)
		else $error("non-config access answered with zero command");

endmodule

// ==== pci_bus_agent.sv ====
// far side bus agent: raises target requests and detected parity errors
// assumes the device answers a target request one clock after it is taken
`timescale 1ns/1ps
module pci_bus_agent (
	input wire logic mclk, // pci clock
	input wire logic tgt_claim_q, // device claims the access
	input wire logic tgt_snoop_q, // device snoops the access
	output logic tgt_req, // target request pulse
	output logic [3:0] tgt_space, // space of the request
	output logic tgt_palette_wr, // request is a palette write
	output logic data_perr_det, // data parity error pulse
	output logic addr_perr_det // address parity error pulse
);
	// idle levels from time zero
	initial begin
		tgt_req = 1'h0;
		tgt_space = 4'h0;
		tgt_palette_wr = 1'h0;
		data_perr_det = 1'h0;
		addr_perr_det = 1'h0;
	end

	// one request; qualifiers held to the taking edge, then inverted so stale values never help
	task automatic target(input logic [3:0] sp, input logic pal, output logic claim, output logic snoop);
		@(posedge mclk);
		#1;
		tgt_req = 1'h1;
		tgt_space = sp;
		tgt_palette_wr = pal;
		@(posedge mclk);
		#1;
		tgt_req = 1'h0;
		tgt_space = ~sp;
		tgt_palette_wr = ~pal;
		claim = tgt_claim_q;
		snoop = tgt_snoop_q;
	endtask

	// one-cycle pulse of the parity error detectors
	task automatic perr_pulse(input logic dat, input logic adr);
		@(posedge mclk);
		#1;
		data_perr_det = dat;
		addr_perr_det = adr;
		@(posedge mclk);
		#1;
		data_perr_det = 1'h0;
		addr_perr_det = 1'h0;
	endtask
endmodule

// ==== pci_command_control_bits_tb.sv ====
// self-checking bench for the command control bank
// assumes outputs answer one clock after each request is taken
`timescale 1ns/1ps
module pci_command_control_bits_tb;
	import pci_cmd_pkg::*;
	logic mclk, rst_n, cfg_wr, cfg_rd, mst_req, mst_want_inval;
	logic [7:0] cfg_addr;
	logic [1:0] cfg_be;
	logic [15:0] cfg_wdata, cfg_rdata_q, rd, cmd;
	logic cfg_ack_q, tgt_req, tgt_palette_wr, tgt_claim_q, tgt_snoop_q, mst_go_q, mst_inval_q, step_en_q;
	logic data_perr_det, addr_perr_det, perr_n_q, perr_oe_q, serr_n_q, serr_oe_q, det_parity_err_q, par_out_q;
	logic [3:0] tgt_space, cbe_out;
	logic [31:0] ad_out;
	logic c, s;
	int failures, tests_run, cycles;

	pci_command_control_bits i_dut (.mclk(mclk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
		.cfg_ack_q(cfg_ack_q), .tgt_req(tgt_req), .tgt_space(tgt_space), .tgt_palette_wr(tgt_palette_wr),
		.tgt_claim_q(tgt_claim_q), .tgt_snoop_q(tgt_snoop_q), .mst_req(mst_req),
		.mst_want_inval(mst_want_inval), .mst_go_q(mst_go_q), .mst_inval_q(mst_inval_q),
		.step_en_q(step_en_q), .data_perr_det(data_perr_det), .addr_perr_det(addr_perr_det),
		.perr_n_q(perr_n_q), .perr_oe_q(perr_oe_q), .serr_n_q(serr_n_q), .serr_oe_q(serr_oe_q),
		.det_parity_err_q(det_parity_err_q), .ad_out(ad_out), .cbe_out(cbe_out), .par_out_q(par_out_q));

	pci_bus_agent i_agent (.mclk(mclk), .tgt_claim_q(tgt_claim_q), .tgt_snoop_q(tgt_snoop_q),
		.tgt_req(tgt_req), .tgt_space(tgt_space), .tgt_palette_wr(tgt_palette_wr),
		.data_perr_det(data_perr_det), .addr_perr_det(addr_perr_det));

	// ****************************************************************
	// clock, hang guard and shared tasks
	// ****************************************************************
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end

	// cut a hang short well beyond the expected hundred-odd cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one config access, answer and ack taken one clock later
	task automatic cfg(input logic wr, input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
		@(posedge mclk);
		#1;
		cfg_wr = wr;
		cfg_rd = ~wr;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d;
		@(posedge mclk);
		#1;
		cfg_wr = 1'h0;
		cfg_rd = 1'h0;
		cfg_wdata = ~d;
		rd = cfg_rdata_q;
		check("cfg_ack", {15'h0, cfg_ack_q}, 16'h0001);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string name);
		cfg(1'h0, a, 2'h3, 16'h0000);
		check(name, rd, exp);
	endtask

	task automatic master(input logic want, input logic go_e, input logic inv_e);
		@(posedge mclk);
		#1;
		mst_req = 1'h1;
		mst_want_inval = want;
		@(posedge mclk);
		#1;
		mst_req = 1'h0;
		check("mst_go", {15'h0, mst_go_q}, {15'h0, go_e});
		check("mst_inval", {15'h0, mst_inval_q}, {15'h0, inv_e});
	endtask

	task automatic perr_chk(input logic pe, input logic se);
		check("perr_oe", {15'h0, perr_oe_q}, {15'h0, pe});
		check("perr_n", {15'h0, perr_n_q}, {15'h0, ~pe});
		check("serr_oe", {15'h0, serr_oe_q}, {15'h0, se});
		check("serr_n", {15'h0, serr_n_q}, {15'h0, ~se});
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{rst_n, cfg_wr, cfg_rd, mst_req, mst_want_inval} = 5'h00;
		{cfg_addr, cfg_be, cfg_wdata, ad_out, cbe_out} = 62'h0;
		repeat (3) @(posedge mclk);
		#1;
		rst_n = 1'h1;
		rd_chk(CMD_REG_OFFSET, CMD_RESET, "cmd_reset");
		rd_chk(STATUS_REG_OFFSET, 16'h0000, "status_reset");
		// only writable command bits stick, stepping reads zero
		cfg(1'h1, CMD_REG_OFFSET, 2'h3, 16'hffff);
		rd_chk(CMD_REG_OFFSET, 16'h0157, "cmd_mask");
		check("step_en", {15'h0, step_en_q}, 16'h0000);
		rd_chk(8'h08, 16'h0000, "unmapped");
		cfg(1'h1, CMD_REG_OFFSET, 2'h1, 16'h0000);
		rd_chk(CMD_REG_OFFSET, 16'h0100, "cmd_low_byte");
		@(posedge mclk);
		#1;
		rst_n = 1'h0;
		@(posedge mclk);
		#1;
		rst_n = 1'h1;
		rd_chk(CMD_REG_OFFSET, 16'h0000, "cmd_rereset");
		// claims against each space, palette write last
		for (int m = 0; m < 4; m++) begin
			cmd = 16'(m);
			cfg(1'h1, CMD_REG_OFFSET, 2'h3, cmd);
			for (int i = 0; i < 5; i++) begin
				i_agent.target(i < 4 ? 4'(1 << i) : 4'(SPACE_IO), 1'(i == 4), c, s);
				check("tgt_claim", {15'h0, c}, {15'h0, i == 0 || (i == 1 && cmd[1]) || (i >= 2 && i != 3 && cmd[0])});
				check("tgt_snoop", {15'h0, s}, 16'h0000);
			end
		end
		master(1'h1, 1'h0, 1'h0);
		cfg(1'h1, CMD_REG_OFFSET, 2'h3, 16'h0004);
		master(1'h1, 1'h1, 1'h0);
		cfg(1'h1, CMD_REG_OFFSET, 2'h3, 16'h0014);
		master(1'h1, 1'h1, 1'h1);
		master(1'h0, 1'h1, 1'h0);
		// silent error still flags status, then write-one clears it
		cfg(1'h1, CMD_REG_OFFSET, 2'h3, 16'h0000);
		i_agent.perr_pulse(1'h1, 1'h0);
		perr_chk(1'h0, 1'h0);
		check("det_parity", {15'h0, det_parity_err_q}, 16'h0001);
		rd_chk(STATUS_REG_OFFSET, 16'h8000, "status_set");
		cfg(1'h1, STATUS_REG_OFFSET, 2'h2, 16'h8000);
		rd_chk(STATUS_REG_OFFSET, 16'h0000, "status_clear");
		cfg(1'h1, CMD_REG_OFFSET, 2'h3, 16'h0040);
		i_agent.perr_pulse(1'h1, 1'h0);
		perr_chk(1'h1, 1'h0);
		i_agent.perr_pulse(1'h0, 1'h1);
		perr_chk(1'h0, 1'h0);
		cfg(1'h1, CMD_REG_OFFSET, 2'h3, 16'h0140);
		i_agent.perr_pulse(1'h0, 1'h1);
		perr_chk(1'h0, 1'h1);
		// parity generated with checking off as well
		cfg(1'h1, CMD_REG_OFFSET, 2'h3, 16'h0000);
		for (int k = 0; k < 6; k++) begin
			@(posedge mclk);
			#1;
			ad_out = 32'h9e37_79b9 * k;
			cbe_out = 4'(k * 5);
			@(posedge mclk);
			#1;
			check("par_out", {15'h0, par_out_q}, {15'h0, ^{ad_out, cbe_out}});
		end
		final_report();
	end
endmodule
